// ==== design/lpt_pkg.sv ====
// Shared constants and types for the pixel lookup table host port
package lpt_pkg;
	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int LANES = 4; // Pixel lanes in the stream word
	localparam int PIX_W = 8; // Bits per pixel and per table entry
	localparam int BANK_W = 2; // Bank select width
	localparam int LANE_W = 2; // Lane select width
	localparam int INDEX_W = 8; // Table index width
	localparam int TAB_ADDR_W = BANK_W + INDEX_W; // Bank and index form one lane address
	localparam int FIFO_DEPTH = 8; // Words buffered ahead of the table
	localparam int DATA_W = 32; // Bus and stream word width

	// ----------------------------------------
	// Control word layout, one firmware variant
	// ----------------------------------------
	localparam int WIN_LSB = 0; // Data window byte
	localparam int INSERT_BIT = 15; // Table in the pixel path
	localparam int INDEX_LSB = 16; // Host table index
	localparam int BANK_LSB = 24; // Bank select
	localparam int DIR_BIT = 27; // Host data direction
	localparam int LANE_LSB = 28; // Host lane select
	localparam int COMMIT_BIT = 30; // Commit strobe, write only
	localparam int OPEN_BIT = 31; // Host port open

	// Byte lanes of the control word
	localparam int SEL_WIN = 0;
	localparam int SEL_INS = 1;
	localparam int SEL_IDX = 2;
	localparam int SEL_TOP = 3;

	// Word index of the control register on the bus
	localparam int CTRL_WORD = 0;

	// Host data direction
	typedef enum logic {
		DIR_READ = 1'b0,
		DIR_WRITE = 1'b1
	} lpt_dir_t;
endpackage

// ==== design/lpt_tab_if.sv ====
// Host side access bundle between the control logic and the table lanes
`timescale 1ns/100ps
interface lpt_tab_if #(
	parameter int LANES = 4,
	parameter int ADDR_W = 10
);
	logic [ADDR_W-1:0] addr; // Bank and index of the host access
	logic [7:0] wdata; // Byte to store on commit
	logic [LANES-1:0] we; // One-cycle store pulse per lane
	logic [7:0] rdata [LANES]; // Stored byte per lane at addr

	// Control end
	modport ctrl(output addr, output wdata, output we, input rdata);
	// Lane end
	modport lane(input addr, input wdata, input we, output rdata);
endinterface

// ==== design/lpt_fifo.sv ====
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
module lpt_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Fill side
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	// Drain side
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage words
		logic [AW-1:0] wrPtr; // Next slot to fill
		logic [AW-1:0] rdPtr; // Oldest word
		logic [AW:0] count; // Words held
		logic notFull; // Registered room flag
		logic notEmpty; // Registered data flag
	} lpt_fifo_state_t;

	lpt_fifo_state_t st;
	lpt_fifo_state_t next_st;
	logic push; // Word taken this cycle
	logic pop; // Word given this cycle

	assign push = inValid && st.notFull;
	assign pop = outReady && st.notEmpty;
	assign inReady = st.notFull;
	assign outValid = st.notEmpty;
	assign outData = st.mem[st.rdPtr];

	// Next state: pointers wrap at DEPTH, flags follow the new count
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wrPtr] = inData;
			next_st.wrPtr = (st.wrPtr == AW'(DEPTH - 1)) ? '0 : AW'(st.wrPtr + 1'b1);
		end
		if (pop) begin
			next_st.rdPtr = (st.rdPtr == AW'(DEPTH - 1)) ? '0 : AW'(st.rdPtr + 1'b1);
		end
		// Simultaneous push and pop keep the count
		if (push && !pop) begin
			next_st.count = (AW+1)'(st.count + 1'b1);
		end else if (pop && !push) begin
			next_st.count = (AW+1)'(st.count - 1'b1);
		end
		next_st.notFull = next_st.count != (AW+1)'(DEPTH);
		next_st.notEmpty = next_st.count != '0;
	end

	// Register, empty with room after reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st <= '{default: '0, notFull: 1'b1};
		end else begin
			st <= next_st;
		end
	end
endmodule

// ==== design/lpt_lut_lane.sv ====
// One lane of the lookup table: pixel read port and host read and write port
`timescale 1ns/100ps
module lpt_lut_lane #(
	parameter int LANE = 0,
	parameter int ADDR_W = 10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Host access
	lpt_tab_if.lane tab,
	// Pixel lookup
	input wire logic [ADDR_W-1:0] pixAddr,
	input wire logic pixEn,
	output logic [7:0] pixByte
);
	// Table bytes for all banks of this lane; not reset, contents are software's
	logic [7:0] mem [2**ADDR_W];

	typedef struct packed {
		logic [7:0] pixRd; // Lookup result, held while stalled
		logic [7:0] hostRd; // Host view of addr
	} lpt_lane_state_t;

	lpt_lane_state_t st;
	lpt_lane_state_t next_st;

	assign pixByte = st.pixRd;
	assign tab.rdata[LANE] = st.hostRd;

	// Both reads are synchronous so the table maps onto block memory
	always_comb begin
		next_st = st;
		if (pixEn) begin
			next_st.pixRd = mem[pixAddr];
		end
		next_st.hostRd = mem[tab.addr];
	end

	// Commit stores the window byte
	always_ff @(posedge clk) begin
		if (tab.we[LANE]) begin
			mem[tab.addr] <= tab.wdata;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

// ==== design/lpt_host_port.sv ====
// Pixel lookup table with Wishbone host control register and pixel stream path
// Function
// - Insert bit routes pixels through table or around
// - Bank select for host and pixel path
// - Lane select steers host access
// - Index addresses host reads and writes
// - Data window carries table byte indirectly
// - Direction read: window shows table, writes ignored
// - Direction write: window is plain holding register
// - Commit copies window into table when writing
// - Port open bit gates host table access
// - Field layout is one firmware variant
`timescale 1ns/100ps
module lpt_host_port #(
	parameter int ADR_W = 4,
	parameter int FIFO_DEPTH = lpt_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Wishbone slave
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [ADR_W-1:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [31:0] wbDatI,
	output logic [31:0] wbDatO,
	output logic wbAck,
	// Pixel stream in
	input wire logic pixInValid,
	input wire logic [31:0] pixIn,
	output logic pixInReady,
	// Pixel stream out
	output logic pixOutValid,
	output logic [31:0] pixOut,
	input wire logic pixOutReady
);
	localparam int PW = lpt_pkg::PIX_W;
	localparam int LN = lpt_pkg::LANES;
	localparam int BW = lpt_pkg::BANK_W;
	localparam int LW = lpt_pkg::LANE_W;
	localparam int IW = lpt_pkg::INDEX_W;
	localparam int DW = lpt_pkg::DATA_W;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic ack; // Bus answer
		logic [DW-1:0] rdata; // Read data, valid with ack
		logic open; // Host port open
		lpt_pkg::lpt_dir_t dir; // Host data direction
		logic [LW-1:0] lane; // Host lane
		logic [BW-1:0] bank; // Bank for host and pixels
		logic [IW-1:0] index; // Host table index
		logic insert; // Table in pixel path
		logic [PW-1:0] window; // Holding register of the window
		logic commit; // One-cycle store pulse
		logic s1Valid; // Lookup stage holds a word
		logic s1Ins; // Insert bit seen with that word
		logic [DW-1:0] s1Raw; // Untranslated word
		logic outValid; // Output register holds a word
		logic [DW-1:0] outData; // Output word
	} lpt_top_state_t;

	lpt_top_state_t st;
	lpt_top_state_t next_st;

	logic wbReq; // New bus request this cycle
	logic hit; // Request addresses the control word
	logic adv; // Pixel pipeline moves
	logic fifoValid; // Buffered word available
	logic [DW-1:0] fifoData; // Oldest buffered word
	logic [DW-1:0] lookupWord; // Translated word from the lanes
	logic [PW-1:0] windowView; // Window as software reads it
	logic [DW-1:0] ctrlView; // Control word as software reads it

	lpt_tab_if #(.LANES(LN), .ADDR_W(lpt_pkg::TAB_ADDR_W)) tab();

	// ----------------------------------------
	// Buffer ahead of the table
	// ----------------------------------------
	lpt_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.nrst(nrst),
		.inValid(pixInValid),
		.inData(pixIn),
		.inReady(pixInReady),
		.outValid(fifoValid),
		.outData(fifoData),
		.outReady(adv)
	);

	// ----------------------------------------
	// Table lanes
	// ----------------------------------------
	for (genvar i = 0; i < LN; i++) begin : g_lane
		// Pixel byte of this lane indexes the active bank
		lpt_lut_lane #(.LANE(i), .ADDR_W(lpt_pkg::TAB_ADDR_W)) u_lane (
			.clk(clk),
			.nrst(nrst),
			.tab(tab.lane),
			.pixAddr({st.bank, fifoData[i*PW +: PW]}),
			.pixEn(adv),
			.pixByte(lookupWord[i*PW +: PW])
		);
		// Only the selected lane takes the commit
		assign tab.we[i] = st.commit && (st.lane == LW'(i));
	end

	// Host access point from the registered fields
	assign tab.addr = {st.bank, st.index};
	assign tab.wdata = st.window;

	// Outputs straight from the state register
	assign wbAck = st.ack;
	assign wbDatO = st.rdata;
	assign pixOutValid = st.outValid;
	assign pixOut = st.outData;

	// ----------------------------------------
	// Bus decode and read view
	// ----------------------------------------
	assign wbReq = wbCyc && wbStb && !st.ack;
	assign hit = wbAdr[ADR_W-1:2] == (ADR_W-2)'(lpt_pkg::CTRL_WORD);
	// Output register frees when empty or taken
	assign adv = !st.outValid || pixOutReady;

	// Window: table byte in read direction, holding register in write direction
	always_comb begin
		windowView = st.window;
		if (st.dir == lpt_pkg::DIR_READ) begin
			// Closed port shows nothing of the table
			windowView = st.open ? tab.rdata[st.lane] : '0;
		end
	end

	// Control word; commit and reserved bits read as zero
	always_comb begin
		ctrlView = '0;
		ctrlView[lpt_pkg::WIN_LSB +: PW] = windowView;
		ctrlView[lpt_pkg::INSERT_BIT] = st.insert;
		ctrlView[lpt_pkg::INDEX_LSB +: IW] = st.index;
		ctrlView[lpt_pkg::BANK_LSB +: BW] = st.bank;
		ctrlView[lpt_pkg::DIR_BIT] = st.dir;
		ctrlView[lpt_pkg::LANE_LSB +: LW] = st.lane;
		ctrlView[lpt_pkg::OPEN_BIT] = st.open;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.ack = wbReq;
		next_st.rdata = '0;
		next_st.commit = 1'b0;
		// Unmapped words are acknowledged, read zero and ignore writes
		if (wbReq && !wbWe && hit) begin
			next_st.rdata = ctrlView;
		end
		if (wbReq && wbWe && hit) begin
			if (wbSel[lpt_pkg::SEL_TOP]) begin
				next_st.open = wbDatI[lpt_pkg::OPEN_BIT];
				next_st.dir = lpt_pkg::lpt_dir_t'(wbDatI[lpt_pkg::DIR_BIT]);
				next_st.lane = wbDatI[lpt_pkg::LANE_LSB +: LW];
				next_st.bank = wbDatI[lpt_pkg::BANK_LSB +: BW];
			end
			if (wbSel[lpt_pkg::SEL_IDX]) begin
				next_st.index = wbDatI[lpt_pkg::INDEX_LSB +: IW];
			end
			if (wbSel[lpt_pkg::SEL_INS]) begin
				next_st.insert = wbDatI[lpt_pkg::INSERT_BIT];
			end
			// Direction after this write decides; this word sets it only with the top byte selected
			if (wbSel[lpt_pkg::SEL_WIN] && next_st.dir == lpt_pkg::DIR_WRITE) begin
				next_st.window = wbDatI[lpt_pkg::WIN_LSB +: PW];
			end
			// Store lands one cycle later, after the fields have settled
			if (wbSel[lpt_pkg::SEL_TOP] && wbDatI[lpt_pkg::COMMIT_BIT]
					&& next_st.dir == lpt_pkg::DIR_WRITE && next_st.open) begin
				next_st.commit = 1'b1;
			end
		end
		// Pixel pipeline: buffer, lookup stage, output register
		if (adv) begin
			next_st.s1Valid = fifoValid;
			next_st.s1Raw = fifoData;
			next_st.s1Ins = st.insert;
			next_st.outValid = st.s1Valid;
			// Bypass passes the word untouched
			next_st.outData = st.s1Ins ? lookupWord : st.s1Raw;
		end
	end

	// Register all state; fields reset to zero, so table bypassed and port closed
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	chk_bypass_data: assert property (
		(adv && st.s1Valid && !st.s1Ins) |=> (pixOut == $past(st.s1Raw)))
		else $error("bypass word altered");
	chk_lookup_data: assert property (
		(adv && st.s1Valid && st.s1Ins) |=> (pixOut == $past(lookupWord)))
		else $error("inserted word not translated");
	// Bank written over the bus is the bank both table ports then use
	chk_bank_written: assert property (
		(wbReq && wbWe && hit && wbSel[lpt_pkg::SEL_TOP])
		|=> (st.bank == $past(wbDatI[lpt_pkg::BANK_LSB +: BW])))
		else $error("bank select not applied");
	chk_window_ignored: assert property (
		(wbReq && wbWe && hit && next_st.dir == lpt_pkg::DIR_READ)
		|=> (st.window == $past(st.window)))
		else $error("window written in read direction");
	chk_window_hold: assert property (
		(wbReq && wbWe && hit && wbSel[lpt_pkg::SEL_WIN]
			&& next_st.dir == lpt_pkg::DIR_WRITE)
		|=> (st.window == $past(wbDatI[lpt_pkg::WIN_LSB +: PW])))
		else $error("window not held");
	chk_commit_gated: assert property (
		(tab.we != '0) |-> (st.dir == lpt_pkg::DIR_WRITE && st.open))
		else $error("store outside write direction");
	chk_commit_lane: assert property (
		st.commit |-> (tab.we == (LN'(1) << st.lane)))
		else $error("store reached wrong lane");
	chk_commit_pulse: assert property (
		st.commit |=> !st.commit ##1 (st.ack || !st.commit))
		else $error("commit longer than one cycle");
	chk_commit_reads_zero: assert property (
		$rose(wbAck) && !$past(wbWe) |-> !wbDatO[lpt_pkg::COMMIT_BIT])
		else $error("commit bit read back set");
	chk_closed_read: assert property (
		(wbReq && !wbWe && hit && !st.open && st.dir == lpt_pkg::DIR_READ)
		|=> (wbDatO[lpt_pkg::WIN_LSB +: PW] == '0))
		else $error("table visible while port closed");
	chk_ack_once: assert property (
		wbReq |=> wbAck ##1 !wbAck)
		else $error("ack not single cycle");

	cov_commit: cover property (st.commit ##[1:20] (wbAck && !$past(wbWe)));
	cov_lookup: cover property (adv && st.s1Valid && st.s1Ins);
	cov_stall: cover property (!pixInReady ##1 pixOutValid && pixOutReady);
	cov_table_read: cover property (wbReq && !wbWe && st.open
		&& st.dir == lpt_pkg::DIR_READ);
endmodule

// ==== tb/lpt_host_port_bench.sv ====
// Self-checking bench for the pixel lookup table host port
`timescale 1ns/100ps
module lpt_host_port_bench;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk = 1'b0; // 20 MHz bench clock
	logic nrst = 1'b0; // Active low reset
	logic wbCyc = 1'b0; // Bus cycle
	logic wbStb = 1'b0; // Bus strobe
	logic wbWe = 1'b0; // Bus direction
	logic [3:0] wbAdr = 4'h0; // Byte address
	logic [3:0] wbSel = 4'hf; // Byte lanes of the request
	logic [31:0] wbDatI = 32'h0; // Write data
	logic [31:0] wbDatO; // Read data
	logic wbAck; // Bus answer
	logic pixInValid = 1'b0; // Stream in valid
	logic [31:0] pixIn = 32'h0; // Stream in word
	logic pixInReady; // Stream in ready
	logic pixOutValid; // Stream out valid
	logic [31:0] pixOut; // Stream out word
	logic pixOutReady = 1'b0; // Stream out ready
	int error_cnt = 0; // Mismatches
	int cmp_count = 0; // Comparisons
	int cycles = 0; // Timeout counter

	// Half period inversion
	always #25 clk = ~clk;

	lpt_host_port #(.ADR_W(4), .FIFO_DEPTH(8)) i_lpt_host_port (.clk(clk), .nrst(nrst),
		.wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
		.wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .pixInValid(pixInValid),
		.pixIn(pixIn), .pixInReady(pixInReady), .pixOutValid(pixOutValid),
		.pixOut(pixOut), .pixOutReady(pixOutReady));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Verdict and end of run
	task automatic results;
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Cuts a hang short; tests need well under this
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			error_cnt++;
			$display("ERROR %0t: timeout", $time);
			results();
		end
	end

	// Four-state compare
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	// One classic cycle; waits for ack, only the bench timeout ends a hang
	task automatic wbXfer(input logic we, input logic [3:0] adr, input logic [31:0] dat,
		output logic [31:0] q, input logic [3:0] sel = 4'hf);
		@(posedge clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= adr;
		wbSel <= sel;
		wbDatI <= dat;
		do begin
			@(posedge clk);
		end while (wbAck !== 1'b1);
		q = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask

	// Control word in the package field layout
	function automatic logic [31:0] ctl(input logic op, input logic cm, input logic dr,
		input logic [1:0] ln, input logic [1:0] bk, input logic [7:0] ix, input logic ins,
		input logic [7:0] w);
		return {op, cm, ln, dr, 1'b0, bk, ix, ins, 7'h0, w};
	endfunction

	task automatic wr(input logic [31:0] d);
		logic [31:0] q;
		wbXfer(1'b1, 4'h0, d, q);
	endtask

	task automatic rdChk(input logic [31:0] e, input string m);
		logic [31:0] q;
		wbXfer(1'b0, 4'h0, 32'h0, q);
		check(q, e, m);
	endtask

	// Setup first, then commit, as software must
	task automatic programEntry(input logic [1:0] bk, ln, input logic [7:0] ix, v);
		wr(ctl(1'b1, 1'b0, 1'b1, ln, bk, ix, 1'b0, v));
		wr(ctl(1'b1, 1'b1, 1'b1, ln, bk, ix, 1'b0, v));
	endtask

	task automatic readEntry(input logic [1:0] bk, ln, input logic [7:0] ix, e);
		wr(ctl(1'b1, 1'b0, 1'b0, ln, bk, ix, 1'b0, 8'h0));
		rdChk(ctl(1'b1, 1'b0, 1'b0, ln, bk, ix, 1'b0, e), "entry");
	endtask

	// Pixel byte and its table image
	function automatic logic [31:0] pixWord(input int k, input logic ins);
		logic [31:0] w;
		logic [7:0] v;
		for (int l = 0; l < 4; l++) begin
			v = 8'(k * 4 + l + 128);
			w[8*l+:8] = ins ? 8'(v * 3 + 33) : v;
		end
		return w;
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic testReset;
		rdChk(32'h0, "reset value");
		check({31'h0, pixInReady}, 32'h1, "ready after reset");
		check({31'h0, pixOutValid}, 32'h0, "no output after reset");
		$display("test reset done");
	endtask

	// Every bank and lane holds its own byte
	task automatic testEntries;
		for (int b = 0; b < 4; b++)
			for (int l = 0; l < 4; l++)
				programEntry(2'(b), 2'(l), 8'h33, 8'(16 * b + l + 1));
		programEntry(2'h0, 2'h0, 8'h34, 8'he1);
		for (int b = 0; b < 4; b++)
			for (int l = 0; l < 4; l++)
				readEntry(2'(b), 2'(l), 8'h33, 8'(16 * b + l + 1));
		readEntry(2'h0, 2'h0, 8'h34, 8'he1);
		$display("test entries done");
	endtask

	task automatic testWindow;
		logic [31:0] q;
		wr(ctl(1'b1, 1'b0, 1'b1, 2'h0, 2'h0, 8'h33, 1'b0, 8'hc3));
		rdChk(ctl(1'b1, 1'b0, 1'b1, 2'h0, 2'h0, 8'h33, 1'b0, 8'hc3), "holding");
		wr(ctl(1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 8'h33, 1'b0, 8'h77));
		rdChk(ctl(1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 8'h33, 1'b0, 8'h01), "ignored");
		wr(ctl(1'b1, 1'b1, 1'b0, 2'h0, 2'h0, 8'h33, 1'b0, 8'h55));
		rdChk(ctl(1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 8'h33, 1'b0, 8'h01), "no commit");
		// Window lane alone: other fields and the commit bit stay out
		wr(ctl(1'b1, 1'b0, 1'b1, 2'h0, 2'h0, 8'h33, 1'b0, 8'hc3));
		wbXfer(1'b1, 4'h0, ctl(1'b0, 1'b1, 1'b0, 2'h3, 2'h3, 8'hff, 1'b1, 8'h5a), q, 4'h1);
		rdChk(ctl(1'b1, 1'b0, 1'b1, 2'h0, 2'h0, 8'h33, 1'b0, 8'h5a), "byte lane");
		$display("test window done");
	endtask

	// Closed port stores nothing in the table and shows none of it; the window holding register still takes and shows its byte
	task automatic testClosed;
		wr(ctl(1'b0, 1'b1, 1'b1, 2'h0, 2'h0, 8'h33, 1'b0, 8'h99));
		rdChk(ctl(1'b0, 1'b0, 1'b1, 2'h0, 2'h0, 8'h33, 1'b0, 8'h99), "closed hold");
		wr(ctl(1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 8'h33, 1'b0, 8'h0));
		rdChk(ctl(1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 8'h33, 1'b0, 8'h0), "closed read");
		readEntry(2'h0, 2'h0, 8'h33, 8'h01);
		$display("test closed done");
	endtask

	task automatic testUnmapped;
		logic [31:0] q;
		wbXfer(1'b1, 4'h4, 32'hffffffff, q);
		wbXfer(1'b0, 4'h4, 32'h0, q);
		check(q, 32'h0, "unmapped read");
		rdChk(ctl(1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 8'h33, 1'b0, 8'h01), "untouched");
		$display("test unmapped done");
	endtask

	// Fill until refused with output stalled, then drain and compare
	task automatic testPixels(input logic ins);
		logic [31:0] q[$];
		int k;
		k = 0;
		wr(ctl(1'b1, 1'b0, 1'b0, 2'h0, 2'h2, 8'h0, ins, 8'h0));
		@(posedge clk);
		pixInValid <= 1'b1;
		pixIn <= pixWord(0, 1'b0);
		repeat (20) begin
			@(posedge clk);
			if (pixInValid === 1'b1 && pixInReady === 1'b1) begin
				q.push_back(pixWord(k, ins));
				k++;
				pixIn <= pixWord(k, 1'b0);
			end
		end
		pixInValid <= 1'b0;
		check(32'(k), 32'd10, "words until full");
		pixOutReady <= 1'b1;
		repeat (30) begin
			@(posedge clk);
			if (pixOutValid === 1'b1 && pixOutReady === 1'b1)
				check(pixOut, (q.size() > 0) ? q.pop_front() : 32'h0, "pixel");
		end
		pixOutReady <= 1'b0;
		check(32'(q.size()), 32'h0, "all words out");
		$display("test pixels insert=%0d done", ins);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		testReset();
		testEntries();
		testWindow();
		testClosed();
		testUnmapped();
		// Bank 2 image of every pixel value used
		for (int k = 0; k < 10; k++)
			for (int l = 0; l < 4; l++)
				programEntry(2'h2, 2'(l), 8'(k * 4 + l + 128), 8'((k * 4 + l + 128) * 3 + 33));
		testPixels(1'b0);
		testPixels(1'b1);
		results();
	end
endmodule
